// File: atc_defs.svh
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH

// ****************************************
// command opcodes
// ****************************************
`define ATC_OP_WR_CTRL   8'h08
`define ATC_OP_RD_CTRL   8'h84
`define ATC_OP_TX_EN     8'h40

// ****************************************
// control register fields and reset
// ****************************************
`define ATC_CTRL_RESET   8'h00
`define ATC_BIT_FLOAT    7
`define ATC_BIT_REVERSE  6
`define ATC_BIT_AUTO     5
`define ATC_BIT_LOOP     4
`define ATC_BIT_SENSE    3
`define ATC_BIT_PARITY   2
`define ATC_BIT_SPARE    1
`define ATC_BIT_RATE     0

// ****************************************
// timing
// ****************************************
`define ATC_CLK_NS       20
`define ATC_HS_BIT_NS    10000
`define ATC_HS_HALF_CYC  (`ATC_HS_BIT_NS / (2 * `ATC_CLK_NS))
`define ATC_LS_FACTOR    8
`define ATC_WORD_BITS    32
`define ATC_GAP_BITS     4

`endif

// File: atc_pkg.sv
package atc_pkg;

    typedef enum logic [2:0] {
        ATC_CMD,
        ATC_WRDATA,
        ATC_RDDATA,
        ATC_SKIP
    } atc_cmd_state_t;

    typedef enum logic [1:0] {
        ATC_SER_IDLE,
        ATC_SER_BITS,
        ATC_SER_GAP
    } atc_ser_state_t;

endpackage

// File: atc_spi_byte.sv
`timescale 1ns/100ps
`default_nettype none

// spi mode 0 byte engine, msb first, sck sampled by the core clock
module atc_spi_byte (
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       spi_sck_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_mosi_i,
    input  wire logic       tx_load_i,
    input  wire logic [7:0] tx_byte_i,
    output logic            spi_miso_o,
    output logic            byte_done_o,
    output logic [7:0]      rx_byte_o
);

    logic       sck_d_ff;
    logic [2:0] cnt_ff;
    logic [6:0] sh_in_ff;
    logic [7:0] sh_out_ff;
    logic [7:0] rx_byte_ff;
    logic       done_ff;

    wire rise = spi_sck_i & ~sck_d_ff & ~spi_cs_n_i;
    wire fall = ~spi_sck_i & sck_d_ff & ~spi_cs_n_i;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_d_ff   <= 1'b0;
            cnt_ff     <= 3'h0;
            sh_in_ff   <= 7'h00;
            sh_out_ff  <= 8'h00;
            rx_byte_ff <= 8'h00;
            done_ff    <= 1'b0;
        end else begin
            sck_d_ff <= spi_sck_i;
            done_ff  <= 1'b0;
            if (spi_cs_n_i) begin
                cnt_ff <= 3'h0;
            end else if (rise) begin
                cnt_ff   <= cnt_ff + 3'h1;
                sh_in_ff <= {sh_in_ff[5:0], spi_mosi_i};
                if (cnt_ff == 3'h7) begin
                    rx_byte_ff <= {sh_in_ff, spi_mosi_i};
                    done_ff    <= 1'b1;
                end
            end
            // no shift on the fall that follows a byte boundary, so a fresh load keeps its msb
            if (tx_load_i) begin
                sh_out_ff <= tx_byte_i;
            end else if (fall && cnt_ff != 3'h0) begin
                sh_out_ff <= {sh_out_ff[6:0], 1'b0};
            end
        end
    end

    assign spi_miso_o  = sh_out_ff[7];
    assign byte_done_o = done_ff;
    assign rx_byte_o   = rx_byte_ff;

endmodule

`default_nettype wire

// File: atc_tx_serializer.sv
`timescale 1ns/100ps
`default_nettype none
`include "atc_defs.svh"

// bipolar return-to-zero serializer, word bit 0 first, gap of null bits after each word
module atc_tx_serializer #(
    parameter int WORD_BITS = `ATC_WORD_BITS,
    parameter int GAP_BITS  = `ATC_GAP_BITS
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 half_en_i,
    input  wire logic                 start_i,
    input  wire logic [WORD_BITS-1:0] word_i,
    output logic                      idle_o,
    output logic                      line_hi_o,
    output logic                      line_lo_o
);

    localparam int HW = $clog2(2 * WORD_BITS);

    atc_pkg::atc_ser_state_t st_ff;
    logic [WORD_BITS-1:0]    sh_ff;
    logic [HW-1:0]           half_ff;
    logic                    hi_ff;
    logic                    lo_ff;

    wire last_bit = (half_ff == HW'(2 * WORD_BITS - 1));
    wire last_gap = (half_ff == HW'(2 * GAP_BITS - 1));

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff   <= atc_pkg::ATC_SER_IDLE;
            sh_ff   <= '0;
            half_ff <= '0;
            hi_ff   <= 1'b0;
            lo_ff   <= 1'b0;
        end else begin
            unique case (st_ff)
                atc_pkg::ATC_SER_IDLE: begin
                    if (start_i) begin
                        sh_ff   <= word_i;
                        half_ff <= '0;
                        st_ff   <= atc_pkg::ATC_SER_BITS;
                    end
                end
                atc_pkg::ATC_SER_BITS: begin
                    if (half_en_i) begin
                        half_ff <= half_ff + HW'(1);
                        if (!half_ff[0]) begin
                            hi_ff <= sh_ff[0];
                            lo_ff <= ~sh_ff[0];
                        end else begin
                            hi_ff <= 1'b0;
                            lo_ff <= 1'b0;
                            sh_ff <= sh_ff >> 1;
                        end
                        if (last_bit) begin
                            half_ff <= '0;
                            st_ff   <= atc_pkg::ATC_SER_GAP;
                        end
                    end
                end
                atc_pkg::ATC_SER_GAP: begin
                    if (half_en_i) begin
                        half_ff <= half_ff + HW'(1);
                        if (last_gap) begin
                            st_ff <= atc_pkg::ATC_SER_IDLE;
                        end
                    end
                end
                default: st_ff <= atc_pkg::ATC_SER_IDLE;
            endcase
        end
    end

    assign idle_o    = (st_ff == atc_pkg::ATC_SER_IDLE);
    assign line_hi_o = hi_ff;
    assign line_lo_o = lo_ff;

endmodule

`default_nettype wire

// File: atc_transmit_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "atc_defs.svh"

// Overview of operation
// - opcode 0x08 writes the transmit control register, opcode 0x84 reads it back
// - bit 7 set floats the line driver outputs
// - bit 6 set reverses the first 8 bits of each sent word
// - bit 5 clear holds words until opcode 0x40; set sends as available
// - bit 4 set loops transmitter output to both receiver inputs
// - in loopback, external receive data on both channels is ignored
// - in loopback, external line driver outputs stay at null
// - bit 2 clear sends bit 32 as data; set replaces it with parity
// - parity is odd when bit 3 is 0, even when 1
// - bit 0 clear selects high rate; set selects one eighth of it
module atc_transmit_control #(
    parameter int HALF_CYC  = `ATC_HS_HALF_CYC,
    parameter int LS_FACTOR = `ATC_LS_FACTOR
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        spi_sck_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    input  wire logic [31:0] tx_word_i,
    input  wire logic        tx_valid_i,
    output logic             tx_ready_o,
    output logic             line_hi_o,
    output logic             line_lo_o,
    output logic             line_oe_o,
    input  wire logic        rx1_hi_i,
    input  wire logic        rx1_lo_i,
    input  wire logic        rx2_hi_i,
    input  wire logic        rx2_lo_i,
    output logic             rx1_hi_o,
    output logic             rx1_lo_o,
    output logic             rx2_hi_o,
    output logic             rx2_lo_o,
    output logic [7:0]       ctrl_o
);

    localparam int DW = $clog2(HALF_CYC * LS_FACTOR + 1);

    // ****************************************
    // command decode
    // ****************************************
    atc_pkg::atc_cmd_state_t st_ff;
    atc_pkg::atc_cmd_state_t nxt_st;
    logic [7:0]              ctrl_ff;
    logic [7:0]              nxt_ctrl;
    logic                    armed_ff;
    logic                    nxt_armed;
    logic                    byte_done;
    logic [7:0]              rx_byte;

    wire op_byte  = byte_done && (st_ff == atc_pkg::ATC_CMD);
    wire op_wr    = op_byte && (rx_byte == `ATC_OP_WR_CTRL);
    wire rd_load  = op_byte && (rx_byte == `ATC_OP_RD_CTRL);
    wire op_txen  = op_byte && (rx_byte == `ATC_OP_TX_EN);
    wire wr_data  = byte_done && (st_ff == atc_pkg::ATC_WRDATA);

    atc_spi_byte u_spi (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .spi_sck_i   (spi_sck_i),
        .spi_cs_n_i  (spi_cs_n_i),
        .spi_mosi_i  (spi_mosi_i),
        .tx_load_i   (rd_load),
        .tx_byte_i   (ctrl_ff),
        .spi_miso_o  (spi_miso_o),
        .byte_done_o (byte_done),
        .rx_byte_o   (rx_byte)
    );

    wire float_en = ctrl_ff[`ATC_BIT_FLOAT];
    wire rev_en   = ctrl_ff[`ATC_BIT_REVERSE];
    wire auto_en  = ctrl_ff[`ATC_BIT_AUTO];
    wire loop_en  = ctrl_ff[`ATC_BIT_LOOP];
    wire even_en  = ctrl_ff[`ATC_BIT_SENSE];
    wire par_en   = ctrl_ff[`ATC_BIT_PARITY];
    wire slow_en  = ctrl_ff[`ATC_BIT_RATE];

    // one opcode per chip select; further bytes after a data byte are dropped
    always_comb begin
        nxt_st = st_ff;
        if (spi_cs_n_i) begin
            nxt_st = atc_pkg::ATC_CMD;
        end else if (byte_done) begin
            unique case (st_ff)
                atc_pkg::ATC_CMD: begin
                    if (op_wr) begin
                        nxt_st = atc_pkg::ATC_WRDATA;
                    end else if (rd_load) begin
                        nxt_st = atc_pkg::ATC_RDDATA;
                    end else begin
                        nxt_st = atc_pkg::ATC_SKIP;
                    end
                end
                atc_pkg::ATC_WRDATA: nxt_st = atc_pkg::ATC_SKIP;
                atc_pkg::ATC_RDDATA: nxt_st = atc_pkg::ATC_SKIP;
                atc_pkg::ATC_SKIP:   nxt_st = atc_pkg::ATC_SKIP;
                default:             nxt_st = atc_pkg::ATC_SKIP;
            endcase
        end
    end

    assign nxt_ctrl = wr_data ? rx_byte : ctrl_ff;

    // ****************************************
    // send gating
    // ****************************************
    logic ser_idle;
    logic ser_hi;
    logic ser_lo;

    wire send_ok   = auto_en || armed_ff;
    wire ser_start = tx_valid_i && ser_idle && send_ok;
    // enable opcode releases the queue until it runs dry; a new enable wins over the drain
    assign nxt_armed = op_txen ? 1'b1 :
                       (!tx_valid_i && ser_idle) ? 1'b0 : armed_ff;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff    <= atc_pkg::ATC_CMD;
            ctrl_ff  <= `ATC_CTRL_RESET;
            armed_ff <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            ctrl_ff  <= nxt_ctrl;
            armed_ff <= nxt_armed;
        end
    end

    // ****************************************
    // word formatting
    // ****************************************
    wire [7:0]  lab_rev = {tx_word_i[0], tx_word_i[1], tx_word_i[2], tx_word_i[3],
                           tx_word_i[4], tx_word_i[5], tx_word_i[6], tx_word_i[7]};
    wire [7:0]  lab     = rev_en ? lab_rev : tx_word_i[7:0];
    wire [30:0] body    = {tx_word_i[30:8], lab};
    wire        par_bit = even_en ? (^body) : ~(^body);
    wire        top_bit = par_en ? par_bit : tx_word_i[31];
    wire [31:0] ser_word = {top_bit, body};

    // ****************************************
    // bit rate divider
    // ****************************************
    logic [DW-1:0] div_ff;
    wire  [DW-1:0] div_top = slow_en ? DW'(HALF_CYC * LS_FACTOR - 1)
                                     : DW'(HALF_CYC - 1);
    wire           half_en = (div_ff >= div_top);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_ff <= '0;
        end else begin
            div_ff <= half_en ? '0 : div_ff + DW'(1);
        end
    end

    atc_tx_serializer u_ser (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .half_en_i (half_en),
        .start_i   (ser_start),
        .word_i    (ser_word),
        .idle_o    (ser_idle),
        .line_hi_o (ser_hi),
        .line_lo_o (ser_lo)
    );

    // ****************************************
    // line driver and loopback
    // ****************************************
    assign tx_ready_o = ser_idle && send_ok;
    assign line_oe_o  = ~float_en;
    assign line_hi_o  = ser_hi & ~loop_en;
    assign line_lo_o  = ser_lo & ~loop_en;
    assign rx1_hi_o   = loop_en ? ser_hi : rx1_hi_i;
    assign rx1_lo_o   = loop_en ? ser_lo : rx1_lo_i;
    assign rx2_hi_o   = loop_en ? ser_hi : rx2_hi_i;
    assign rx2_lo_o   = loop_en ? ser_lo : rx2_lo_i;
    assign ctrl_o     = ctrl_ff;

    // ****************************************
    // assertions
    // ****************************************
    chk_write_stores: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_data |=> ctrl_ff == $past(rx_byte))
        else $error("control write not stored");

    chk_read_loads: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        rd_load |=> spi_miso_o == $past(ctrl_ff[7]))
        else $error("readback msb not presented");

    chk_driver_float: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        float_en |-> !line_oe_o)
        else $error("driver not floated");

    chk_label_reverse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ser_start && rev_en) |-> ser_word[7:0] == lab_rev)
        else $error("label not reversed");

    chk_hold_send: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!auto_en && !armed_ff) |-> !ser_start)
        else $error("word sent without enable");

    chk_auto_send: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (auto_en && tx_valid_i && ser_idle) |=> !ser_idle)
        else $error("auto mode did not send");

    chk_loop_route: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        loop_en |-> (rx1_hi_o == ser_hi && rx2_lo_o == ser_lo))
        else $error("loopback route broken");

    chk_rx_ignore: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (loop_en && $stable(loop_en) && $changed(rx1_hi_i) && $stable(ser_hi))
        |-> $stable(rx1_hi_o))
        else $error("external receive data leaks in loopback");

    chk_null_line: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        loop_en |-> (!line_hi_o && !line_lo_o))
        else $error("line not null in loopback");

    chk_data_bit32: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ser_start && !par_en) |-> ser_word[31] == tx_word_i[31])
        else $error("bit 32 not data");

    chk_parity_sense: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ser_start && par_en) |-> (^ser_word) == ~even_en)
        else $error("word parity wrong");

    chk_slow_rate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (half_en && slow_en && $stable(slow_en)) |=> (!half_en || !slow_en) [*8])
        else $error("low rate divider too fast");

    cov_write: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) wr_data);
    cov_txen_send: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!auto_en && op_txen) ##[1:10] ser_start);
    cov_loop_send: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        loop_en && ser_start);
    cov_slow_send: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        slow_en && par_en && ser_start);
    cov_float_send: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        float_en && ser_start);

endmodule

`default_nettype wire

// File: atc_spi_host.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************
// spi host model, mode 0
// ****************************
module atc_spi_host (
    input  wire logic ref_clk_i,
    input  wire logic spi_miso_i,
    output logic      spi_sck_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o
);
    logic busy;

    initial begin
        spi_sck_o  = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
        busy       = 1'b0;
    end

    // mosi means nothing outside a frame, so it keeps moving
    always @(posedge ref_clk_i) begin
        #1;
        if (spi_cs_n_o && !busy) begin
            spi_mosi_o = ~spi_mosi_o;
        end
    end

    // each sck level lasts 4 clocks, four times the minimum
    task automatic frame(input logic [7:0] op, input logic [7:0] dat,
                         input int nbytes, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {op, dat};
        rd = 8'h00;
        busy = 1'b1;
        @(posedge ref_clk_i);
        #1;
        spi_cs_n_o = 1'b0;
        for (int i = 0; i < 8 * nbytes; i++) begin
            spi_mosi_o = sh[15 - i];
            repeat (4) @(posedge ref_clk_i);
            #1;
            spi_sck_o = 1'b1;
            if (i >= 8) begin
                rd = {rd[6:0], spi_miso_i};
            end
            repeat (4) @(posedge ref_clk_i);
            #1;
            spi_sck_o = 1'b0;
        end
        spi_cs_n_o = 1'b1;
        busy = 1'b0;
    endtask
endmodule

`default_nettype wire

// File: atc_transmit_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "atc_defs.svh"

module atc_transmit_control_bench;
    localparam int HALF = 4;
    localparam int LSF  = 8;
    logic        ref_clk_i;
    logic        nrst_i;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic [31:0] tx_word;
    logic        tx_valid;
    logic        tx_ready;
    logic        line_hi;
    logic        line_lo;
    logic        line_oe;
    logic [3:0]  rx_in;
    logic [3:0]  rx_out;
    logic [7:0]  ctrl;
    logic [7:0]  mctrl;
    logic [7:0]  rd;
    logic        chk_en;
    logic        take;
    logic        act;
    logic        prev_act;
    logic [31:0] acc;
    logic [31:0] fifo_q[$];
    logic [31:0] exp_q[$];
    logic [7:0]  cfg[9];
    int          num_errors;
    int          checks_done;
    int          nbit;
    int          cyc;
    int          t0;
    wire         mon_hi = mctrl[4] ? rx_out[3] : line_hi;
    wire         mon_lo = mctrl[4] ? rx_out[2] : line_lo;

    atc_transmit_control #(.HALF_CYC(HALF), .LS_FACTOR(LSF)) dut_u (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .tx_word_i(tx_word), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .line_hi_o(line_hi), .line_lo_o(line_lo),
        .line_oe_o(line_oe), .rx1_hi_i(rx_in[3]), .rx1_lo_i(rx_in[2]),
        .rx2_hi_i(rx_in[1]), .rx2_lo_i(rx_in[0]), .rx1_hi_o(rx_out[3]),
        .rx1_lo_o(rx_out[2]), .rx2_hi_o(rx_out[1]), .rx2_lo_o(rx_out[0]), .ctrl_o(ctrl));

    atc_spi_host host_u (.ref_clk_i(ref_clk_i), .spi_miso_i(miso), .spi_sck_o(sck),
        .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // ****************************
    // compare and report
    // ****************************
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_lvl(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************
    // reference model
    // ****************************
    function automatic logic [31:0] expect_word(input logic [31:0] w);
        logic [31:0] r;
        r = w;
        if (mctrl[6]) begin
            for (int i = 0; i < 8; i++) r[i] = w[7 - i];
        end
        if (mctrl[2]) begin
            r[31] = mctrl[3] ? ^r[30:0] : ~^r[30:0];
        end
        return r;
    endfunction

    always @(negedge ref_clk_i) begin
        take = tx_valid & tx_ready;
    end

    always @(posedge ref_clk_i) begin
        if (take) begin
            exp_q.push_back(expect_word(fifo_q.pop_front()));
        end
        #1;
        rx_in    = 4'($urandom);
        tx_valid = fifo_q.size() > 0;
        tx_word  = tx_valid ? fifo_q[0] : $urandom;
    end

    // line decoder: one pulse start per bit, word bit 0 first
    always @(negedge ref_clk_i) begin
        cyc++;
        act = mon_hi | mon_lo;
        if (nrst_i && chk_en) begin
            if (mctrl[4]) begin
                cmp_lvl({line_hi, line_lo, rx_out[1:0]}, {2'b00, rx_out[3:2]});
            end else begin
                cmp_lvl(rx_out, rx_in);
            end
            cmp_lvl({3'b000, line_oe}, {3'b000, ~mctrl[7]});
            if (act && !prev_act) begin
                if (nbit == 0) t0 = cyc;
                if (nbit == 1) cmp_word(32'(cyc - t0), 32'(2 * HALF * (mctrl[0] ? LSF : 1)));
                acc[nbit] = mon_hi;
                nbit++;
                if (nbit == 32) begin
                    cmp_word(acc, exp_q.size() > 0 ? exp_q.pop_front() : ~acc);
                    nbit = 0;
                end
            end
        end
        prev_act = act;
    end

    // ****************************
    // host access and waits
    // ****************************
    task automatic reg_wr(input logic [7:0] d);
        chk_en = 1'b0;
        host_u.frame(`ATC_OP_WR_CTRL, d, 2, rd);
        mctrl = d;
        @(posedge ref_clk_i);
        #1;
        chk_en = 1'b1;
    endtask

    task automatic reg_rd();
        host_u.frame(`ATC_OP_RD_CTRL, 8'($urandom), 2, rd);
        cmp_reg(rd, mctrl);
        cmp_reg(ctrl, mctrl);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while ((fifo_q.size() > 0 || exp_q.size() > 0 || nbit != 0) && n < 20000) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 20000) begin
            num_errors++;
            $display("CHECK FAILED t=%0t waited=%h limit=%h", $time, n, 20000);
            complete_run();
        end else begin
            // rest of the last bit plus the null gap, at the slow rate
            repeat (12 * HALF * LSF) @(posedge ref_clk_i);
        end
    endtask

    // ****************************
    // main sequence
    // ****************************
    initial begin
        nrst_i = 1'b0;
        tx_valid = 1'b0;
        tx_word = 32'h0000_0000;
        rx_in = 4'h0;
        mctrl = 8'h00;
        chk_en = 1'b0;
        prev_act = 1'b0;
        num_errors = 0;
        checks_done = 0;
        nbit = 0;
        cyc = 0;
        cfg = '{8'h20, 8'h60, 8'h24, 8'h2c, 8'h66, 8'ha4, 8'h30, 8'h21, 8'h6d};
        void'($urandom(67));
        repeat (10) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        chk_en = 1'b1;
        reg_rd();
        // unknown opcode must leave the register alone
        host_u.frame(8'h18, 8'hff, 2, rd);
        reg_rd();
        for (int i = 0; i < 6; i++) begin
            reg_wr(8'($urandom));
            reg_rd();
        end
        reg_wr(8'h02);
        fifo_q.push_back($urandom);
        fifo_q.push_back($urandom);
        repeat (60) @(posedge ref_clk_i);
        cmp_word(32'(fifo_q.size()), 32'd2);
        cmp_lvl({3'b000, tx_ready}, 4'h0);
        host_u.frame(`ATC_OP_TX_EN, 8'h00, 1, rd);
        wait_done();
        cmp_lvl({3'b000, tx_ready}, 4'h0);
        foreach (cfg[k]) begin
            reg_wr(cfg[k]);
            fifo_q.push_back($urandom);
            fifo_q.push_back($urandom);
            wait_done();
            cmp_lvl({3'b000, tx_ready}, {3'b000, mctrl[5]});
            reg_rd();
        end
        // reset in mid-run must clear a non-zero register
        nrst_i = 1'b0;
        mctrl = `ATC_CTRL_RESET;
        repeat (3) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        reg_rd();
        complete_run();
    end
endmodule

`default_nettype wire
